// [reset_delay_watchdog.sv]
// Reset sequencer: delay timer, reset latch, watchdog and cause flags
// Function
// (RULE1) Unprogrammed pin-enable honours external reset; programmed ignores the pin.
// (RULE2) Power-up sets latch, clears timer; count starts when pin high.
// (RULE3) Core held in reset while the delay timer runs.
// (RULE4) RC and external clock modes: 18 ms after power-on, else 10 us.
// (RULE5) Crystal modes: 18 ms delay for every reset.
// (RULE6) Watchdog expiry in sleep also starts the delay timer.
// (RULE7) Reset sources: power-on, pin, watchdog, pin-change wake.
// (RULE8) Watchdog keeps counting while core clock stopped or sleeping.
// (RULE9) Watchdog expiry gives a full reset, running or sleeping.
// (RULE10) Watchdog reset clears the active-low expiry flag, bit 4.
// (RULE11) Watchdog enable programmed zero disables watchdog permanently.
// (RULE12) Base time-out 18 ms; prescaler up to 1:128.
// (RULE13) Config: assign bit 3, ratio bits 2..0; resets to all ones.
// (RULE14) Kick zeroes watchdog counter and assigned prescaler.
// (RULE15) Sleep command zeroes watchdog counter and assigned prescaler.
// (RULE16) Cause flags encoded per reset kind as tabled.
// (RULE17) Cause flags hold until a reset; glitch without reset leaves them.
// (RULE18) Sleep sets expiry flag and clears sleep flag.
// (RULE19) Watchdog cleared on any wake from sleep.
// (RULE20) Prescaler elsewhere: watchdog uses unscaled base period.
// (RULE21) Cause flags updated when reset asserts, before core runs.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
module reset_delay_watchdog
    import rst_seq_pkg::*;
#(
    parameter int LONG_CYC = DELAY_LONG_CYC,
    parameter int SHORT_CYC = DELAY_SHORT_CYC,
    parameter int WDOG_CYC = WDOG_BASE_CYC
)
(
    input wire logic clk,               // 100 MHz clock
    input wire logic arst_n,            // Power-on reset, active low
    input wire logic ext_reset_n,       // External reset pin
    input wire logic pin_change,        // Pin-change wake request
    input wire logic pin_reset_cfg,     // 1 = pin acts as reset
    input wire logic watchdog_enable_cfg, // 1 = watchdog enabled
    input wire osc_mode_type osc_mode,  // Oscillator mode
    input wire logic psel,              // APB select
    input wire logic penable,           // APB enable
    input wire logic pwrite,            // APB direction
    input wire logic [7:0] paddr,       // APB address
    input wire logic [31:0] pwdata,     // APB write data
    output logic [31:0] prdata,         // APB read data
    output logic pready,                // APB ready
    output logic pslverr,               // APB error
    output logic core_reset_n,          // Core reset, active low
    output logic port_pin_in,           // Pin as plain input
    output logic sleeping               // Core in sleep
);

    typedef enum {st_hold, st_delay, st_run} seq_type;

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] pin_sync;
    logic pin_low;
    logic wd_expire;
    logic wd_clear;
    logic kick, sleep_cmd;
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] target_reg, target_next;
    seq_type state_reg, state_next;
    logic por_reg, por_next;
    cause_type cause_reg, cause_next;
    logic sleep_reg, sleep_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic core_next;
    logic crystal;
    logic wr, rd;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // Pin synchroniser, three stages
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_sync <= 3'b111;
        else
            pin_sync <= {pin_sync[1:0], ext_reset_n};
    end

    // Pin low once stages two and three agree; masked when pin is a port
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_low <= 1'b0;
        else if (!pin_reset_cfg)
            pin_low <= 1'b0; // RULE1
        else if (pin_sync[2] == pin_sync[1])
            pin_low <= ~pin_sync[2]; // RULE1
    end

    // Pin as plain input when reset function is off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            port_pin_in <= 1'b1;
        else if (pin_sync[2] == pin_sync[1])
            port_pin_in <= pin_reset_cfg | pin_sync[2]; // RULE1
    end

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign kick = wr && paddr == CTRL_OFS && pwdata[KICK_BIT];
    assign sleep_cmd = wr && paddr == CTRL_OFS && pwdata[SLEEP_CMD_BIT]
        && state_reg == st_run && !sleep_reg;
    assign crystal = osc_mode inside {fast_crystal_mode, std_crystal_mode,
        low_freq_crystal_mode};

    // Clear on kick, sleep entry, wake, and while core is in reset
    assign wd_clear = kick | sleep_cmd | (state_reg != st_run); // RULE14 RULE15 RULE19

    // Watchdog keeps running with the core asleep
    watchdog_timer #(.BASE_CYC(WDOG_CYC)) i_watchdog_timer
    (
        .clk(clk),
        .rst_n(rst_n),
        .enable(watchdog_enable_cfg), // RULE8 RULE11
        .clear(wd_clear),
        .use_prescale(cfg_reg[ASSIGN_BIT]),
        .ratio(cfg_reg[RATIO_MSB:0]),
        .expire(wd_expire)
    );

    // Reset sequencer, cause flags and configuration register
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        target_next = target_reg;
        por_next = por_reg;
        cause_next = cause_reg;
        sleep_next = sleep_reg;
        cfg_next = cfg_reg;
        if (wr && paddr == TIMER_CFG_OFS && state_reg == st_run)
            cfg_next = pwdata[7:0];
        if (sleep_cmd) // RULE18
        begin
            sleep_next = 1'b1;
            cause_next.expiry_flag_n = 1'b1;
            cause_next.sleep_flag_n = 1'b0;
        end
        unique case (state_reg)
            st_hold:
            begin
                cnt_next = 32'h0;
                if (!pin_low) // RULE2
                    state_next = st_delay;
            end
            st_delay:
            begin
                if (pin_low)
                begin
                    state_next = st_hold;
                    cnt_next = 32'h0;
                end
                else if (cnt_reg >= target_reg - 1) // RULE2 RULE3
                begin
                    state_next = st_run;
                    por_next = 1'b0;
                end
                else
                    cnt_next = cnt_reg + 32'h1;
            end
            st_run:
            begin
                // Any reset source restarts the delay; RULE7 RULE9
                if (pin_low || wd_expire || (sleep_reg && pin_change))
                begin
                    state_next = pin_low ? st_hold : st_delay; // RULE6
                    cnt_next = 32'h0;
                    cfg_next = TIMER_CFG_RST; // RULE13
                    sleep_next = 1'b0;
                    target_next = crystal ? 32'(LONG_CYC) // RULE5
                        : 32'(SHORT_CYC); // RULE4
                    // Flags set as reset asserts; RULE16 RULE21
                    cause_next.pin_wake_flag = 1'b0;
                    if (wd_expire)
                    begin
                        cause_next.expiry_flag_n = 1'b0; // RULE10
                        if (sleep_reg)
                            cause_next.sleep_flag_n = 1'b0;
                    end
                    else if (pin_low)
                    begin
                        if (sleep_reg)
                        begin
                            cause_next.expiry_flag_n = 1'b1;
                            cause_next.sleep_flag_n = 1'b0;
                        end
                    end
                    else
                    begin
                        cause_next.pin_wake_flag = 1'b1;
                        cause_next.expiry_flag_n = 1'b1;
                        cause_next.sleep_flag_n = 1'b0;
                    end
                end
            end
        endcase
    end

    // Sequencer registers; power-on values
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= st_hold;
            cnt_reg <= 32'h0;
            target_reg <= 32'(LONG_CYC); // RULE4 RULE5
            por_reg <= 1'b1;
            cause_reg <= 3'b011; // RULE16
            sleep_reg <= 1'b0;
            cfg_reg <= TIMER_CFG_RST; // RULE13
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            target_reg <= target_next;
            por_reg <= por_next;
            cause_reg <= cause_next;
            sleep_reg <= sleep_next;
            cfg_reg <= cfg_next;
        end
    end

    // APB read data and error decode
    always_comb
    begin
        prdata_next = 32'h0;
        pslverr_next = 1'b0;
        if (rd)
        begin
            unique case (paddr)
                TIMER_CFG_OFS: prdata_next = 32'h0;
                CAUSE_OFS:
                begin
                    prdata_next[PIN_WAKE_BIT] = cause_reg.pin_wake_flag;
                    prdata_next[EXPIRY_BIT] = cause_reg.expiry_flag_n;
                    prdata_next[SLEEP_BIT] = cause_reg.sleep_flag_n;
                end
                CTRL_OFS: prdata_next = {31'h0, sleep_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
        else if (psel && !(paddr inside {TIMER_CFG_OFS, CAUSE_OFS, CTRL_OFS}))
            pslverr_next = 1'b1;
    end

    assign core_next = (state_next == st_run); // RULE3

    // Registered outputs; no wait states, pready high in the first access cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            core_reset_n <= 1'b0;
            sleeping <= 1'b0;
        end
        else
        begin
            prdata <= prdata_next;
            pready <= psel & ~penable;
            pslverr <= pslverr_next;
            core_reset_n <= core_next;
            sleeping <= sleep_next;
        end
    end

    // Core held in reset through the delay
    hold_in_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != st_run |-> !core_reset_n) // RULE3
        else $error("core released during delay");
    // Watchdog reset clears expiry flag
    wd_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_run && wd_expire |=> !cause_reg.expiry_flag_n) // RULE10
        else $error("expiry flag not cleared");
    // Disabled watchdog never expires
    wd_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !watchdog_enable_cfg |=> !wd_expire) // RULE11
        else $error("disabled watchdog expired");
    // Sleep entry flags
    sleep_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
        sleep_cmd && !wd_expire && !pin_low |=>
        cause_reg.expiry_flag_n && !cause_reg.sleep_flag_n) // RULE18
        else $error("sleep flags wrong");
    // Pin ignored when reset function off
    pin_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pin_reset_cfg ##1 !pin_reset_cfg |-> !pin_low) // RULE1
        else $error("pin reset while disabled");
    // Config returns to all ones on reset
    cfg_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_run && state_next != st_run
        |=> cfg_reg == TIMER_CFG_RST) // RULE13
        else $error("config not reset");
    // Crystal mode always uses long delay
    xtal_long_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_delay && crystal |-> target_reg == 32'(LONG_CYC)) // RULE5
        else $error("crystal delay short");
    // Power-on delay is always the long one
    por_long_a: assert property (@(posedge clk) disable iff (!rst_n)
        por_reg && state_reg == st_delay |-> target_reg == 32'(LONG_CYC)) // RULE4
        else $error("power-on delay short");
    // Pin-change wake flag
    pin_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_run && sleep_reg && pin_change && !pin_low
        && !wd_expire |=> cause_reg == 3'b110) // RULE16
        else $error("pin wake flags wrong");
    // Flags stable while core held
    flags_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg != st_run |=> $stable(cause_reg)) // RULE17 RULE21
        else $error("flags changed during delay");

    wd_reset_c: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_run && wd_expire);
    sleep_c: cover property (@(posedge clk) disable iff (!rst_n) sleep_cmd);
    pin_reset_c: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg == st_run && pin_low);
    release_c: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(core_reset_n));

endmodule

// [rst_seq_pkg.sv]
// Package of constants and types for the reset delay and watchdog block
package rst_seq_pkg;

    // Clock rate and documented delays
    localparam int CLK_HZ = 100_000_000;
    localparam int DELAY_LONG_US = 18_000;        // 18 ms
    localparam int DELAY_SHORT_NS = 10_000;       // 10 us
    localparam int WDOG_BASE_US = 18_000;         // 18 ms
    localparam int DELAY_LONG_CYC = DELAY_LONG_US * (CLK_HZ / 1_000_000);
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_NS / (1_000_000_000 / CLK_HZ);
    localparam int WDOG_BASE_CYC = WDOG_BASE_US * (CLK_HZ / 1_000_000);

    // APB register byte offsets
    localparam logic [7:0] TIMER_CFG_OFS = 8'h00;
    localparam logic [7:0] CAUSE_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;

    // Timer configuration field positions and reset value
    localparam int ASSIGN_BIT = 3;
    localparam int RATIO_MSB = 2;
    localparam logic [7:0] TIMER_CFG_RST = 8'hFF;

    // Status bit positions of the cause flags
    localparam int PIN_WAKE_BIT = 7;
    localparam int EXPIRY_BIT = 4;
    localparam int SLEEP_BIT = 3;

    // Control register bit positions (write-one strobes)
    localparam int KICK_BIT = 0;
    localparam int SLEEP_CMD_BIT = 1;

    // Oscillator modes
    typedef enum logic [2:0]
    {
        internal_rc_mode,
        external_rc_mode,
        ext_clock_mode,
        fast_crystal_mode,
        std_crystal_mode,
        low_freq_crystal_mode
    } osc_mode_type;

    // Reset cause flags
    typedef struct packed
    {
        logic pin_wake_flag;
        logic expiry_flag_n;
        logic sleep_flag_n;
    } cause_type;

endpackage

// [watchdog_timer.sv]
// Watchdog counter with optional 1:1..1:128 prescaler
`timescale 1ns/10ps
module watchdog_timer
    import rst_seq_pkg::*;
#(
    parameter int BASE_CYC = WDOG_BASE_CYC
)
(
    input wire logic clk,               // System clock
    input wire logic rst_n,             // Synchronised reset
    input wire logic enable,            // Watchdog enabled
    input wire logic clear,             // Zero counter and prescaler
    input wire logic use_prescale,      // Prescaler assigned here
    input wire logic [2:0] ratio,       // Prescale ratio code
    output logic expire                 // One-cycle expiry pulse
);

    logic [31:0] base_reg, base_next;
    logic [7:0] pre_reg, pre_next;
    logic expire_next;
    logic tick;

    // Base tick from counter; prescaler counts ticks
    always_comb
    begin
        tick = (base_reg == BASE_CYC - 1);
        base_next = tick ? 32'h0 : base_reg + 32'h1;
        pre_next = pre_reg;
        expire_next = 1'b0;
        if (tick)
        begin
            if (!use_prescale) // RULE20
                expire_next = 1'b1;
            else if (pre_reg == 8'((1 << ratio) - 1)) // RULE12
            begin
                expire_next = 1'b1;
                pre_next = 8'h00;
            end
            else
                pre_next = pre_reg + 8'h01;
        end
        if (clear || !enable) // RULE14 RULE15 RULE11
        begin
            base_next = 32'h0;
            pre_next = 8'h00;
            expire_next = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_reg <= 32'h0;
            pre_reg <= 8'h00;
            expire <= 1'b0;
        end
        else
        begin
            base_reg <= base_next;
            pre_reg <= pre_next;
            expire <= expire_next;
        end
    end

endmodule

// [reset_pin_driver.sv]
// Model of the external reset pin, its pull-up and the supply supervisor
`timescale 1ns/10ps
module reset_pin_driver
(
    input wire logic clk,           // Bench clock
    input wire logic supply_low,    // Supply below its working level
    input wire logic pin_low,       // Drive the reset pin low
    input wire logic glitch,        // Request one short low spike
    output logic arst_n,            // Power-on reset to the block
    output logic ext_reset_n        // Level seen on the reset pin
);
    logic spike = 1'b0;

    // Spike sits inside one period so that no clock edge sees it
    always @(posedge clk)
    begin
        if (glitch)
        begin
            #3 spike = 1'b1;
            #2 spike = 1'b0;
        end
    end

    // A released pin floats up to its pull-up level
    assign ext_reset_n = !(pin_low || spike);
    assign arst_n = !supply_low;
endmodule

// [reset_delay_watchdog_tb.sv]
// Self-checking bench for the reset sequencer and watchdog block
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
        end \
    end
module reset_delay_watchdog_tb
    import rst_seq_pkg::*;
();
    localparam int LC = 200;
    localparam int SC = 20;
    localparam int WC = 50;
    logic clk = 1'b0;
    logic supply_low = 1'b1;
    logic pin_low = 1'b1;
    logic glitch = 1'b0;
    logic pin_change = 1'b0;
    logic pin_reset_cfg = 1'b1;
    logic wdog_en = 1'b1;
    osc_mode_type osc_mode = internal_rc_mode;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr, core_reset_n, port_pin_in, sleeping;
    logic arst_n, ext_reset_n;
    int fails = 0;
    int n_checks = 0;
    int n_resets = 0;

    // Clock and a count of core reset entries
    always #5 clk = ~clk;
    always @(negedge core_reset_n) n_resets++;

    reset_pin_driver i_reset_pin_driver
    (
        .clk(clk), .supply_low(supply_low), .pin_low(pin_low),
        .glitch(glitch), .arst_n(arst_n), .ext_reset_n(ext_reset_n)
    );

    reset_delay_watchdog #(.LONG_CYC(LC), .SHORT_CYC(SC), .WDOG_CYC(WC))
    i_reset_delay_watchdog
    (
        .clk(clk), .arst_n(arst_n), .ext_reset_n(ext_reset_n),
        .pin_change(pin_change), .pin_reset_cfg(pin_reset_cfg),
        .watchdog_enable_cfg(wdog_en), .osc_mode(osc_mode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_reset_n(core_reset_n),
        .port_pin_in(port_pin_in), .sleeping(sleeping)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic timeout();
        fails++;
        $display("MISMATCH wait_bound exp 1 got 0");
        tally_and_finish();
    endtask

    // One APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 9);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 9)
            timeout();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK("prdata", e, q)
    endtask

    // Waits for the core reset level, counting cycles, within a bound
    task automatic wait_core(input logic v, input int b, output int n);
        n = 0;
        while (core_reset_n !== v)
        begin
            @(posedge clk);
            n++;
            if (n > b)
                timeout();
        end
    endtask

    // Pin reset; n is the hold time counted from the pin going high
    task automatic pin_rst(output int n);
        @(posedge clk);
        pin_low <= 1'b1;
        repeat (10) @(posedge clk);
        pin_low <= 1'b0;
        wait_core(1'b1, 2 * LC, n);
    endtask

    // Cause word from flags {pin wake, expiry_n, sleep_n}
    function automatic logic [31:0] cw(input logic [2:0] f);
        cw = 32'h0;
        cw[PIN_WAKE_BIT] = f[2];
        cw[EXPIRY_BIT] = f[1];
        cw[SLEEP_BIT] = f[0];
    endfunction

    function automatic logic rng(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    // Main sequence
    initial
    begin
        int n;
        int b;
        logic [31:0] q;
        repeat (4) @(posedge clk);
        supply_low <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK("core_reset_n", 1'b0, core_reset_n)
        pin_low <= 1'b0;
        wait_core(1'b1, 2 * LC, n);
        `CHK("por_delay", 1'b1, rng(n, LC, LC + 10))
        rd_chk(CAUSE_OFS, cw(3'b011));
        rd_chk(TIMER_CFG_OFS, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, q);
        `CHK("pslverr", 1'b1, perr)
        // Expiry period for every prescale code, then unscaled
        for (int i = 0; i < 9; i++)
        begin
            b = (i < 8) ? (WC << i) : WC;
            if (i != 7)
                wr(TIMER_CFG_OFS, (i < 8) ? 32'(8 + i) : 32'h7);
            wr(CTRL_OFS, 32'h1 << KICK_BIT);
            wait_core(1'b0, b + 20, n);
            `CHK("expiry", 1'b1, rng(n, b - 2, b + 10))
            wait_core(1'b1, 2 * LC, n);
            `CHK("wdog_delay", 1'b1, rng(n, SC, SC + 10))
            rd_chk(CAUSE_OFS, cw(3'b001));
        end
        // Kicks spaced under one period hold off the expiry
        wr(TIMER_CFG_OFS, 32'h0);
        b = n_resets;
        repeat (6)
        begin
            repeat (WC - 15) @(posedge clk);
            wr(CTRL_OFS, 32'h1 << KICK_BIT);
        end
        `CHK("kick_resets", b, n_resets)
        // Pin reset hold time in every oscillator mode
        for (int m = 0; m < 6; m++)
        begin
            osc_mode <= osc_mode_type'(m);
            b = (m >= 3) ? LC : SC;
            pin_rst(n);
            `CHK("pin_delay", 1'b1, rng(n, b, b + 10))
            rd_chk(CAUSE_OFS, cw(3'b001));
        end
        osc_mode <= internal_rc_mode;
        // A spike between clock edges is no reset
        b = n_resets;
        glitch <= 1'b1;
        @(posedge clk);
        glitch <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("glitch_resets", b, n_resets)
        rd_chk(CAUSE_OFS, cw(3'b001));
        // Sleep, then wake on a pin change
        wr(CTRL_OFS, 32'h1 << SLEEP_CMD_BIT);
        @(posedge clk);
        `CHK("sleeping", 1'b1, sleeping)
        rd_chk(CTRL_OFS, 32'h1);
        rd_chk(CAUSE_OFS, cw(3'b010));
        pin_change <= 1'b1;
        wait_core(1'b0, 20, n);
        pin_change <= 1'b0;
        wait_core(1'b1, 2 * LC, n);
        `CHK("sleeping", 1'b0, sleeping)
        rd_chk(CAUSE_OFS, cw(3'b110));
        // Pin reset during sleep
        wr(CTRL_OFS, 32'h1 << SLEEP_CMD_BIT);
        pin_rst(n);
        rd_chk(CAUSE_OFS, cw(3'b010));
        // Watchdog expiry during sleep gets a full period
        wr(TIMER_CFG_OFS, 32'h0);
        repeat (20) @(posedge clk);
        wr(CTRL_OFS, 32'h1 << SLEEP_CMD_BIT);
        wait_core(1'b0, WC + 20, n);
        `CHK("sleep_expiry", 1'b1, rng(n, WC - 2, WC + 10))
        wait_core(1'b1, 2 * LC, n);
        `CHK("sleep_delay", 1'b1, rng(n, SC, SC + 10))
        rd_chk(CAUSE_OFS, cw(3'b000));
        // Pin configured as a plain input
        pin_reset_cfg <= 1'b0;
        repeat (5) @(posedge clk);
        b = n_resets;
        pin_low <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("port_pin_in", 1'b0, port_pin_in)
        `CHK("pin_resets", b, n_resets)
        pin_low <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("port_pin_in", 1'b1, port_pin_in)
        pin_reset_cfg <= 1'b1;
        // Watchdog disabled by configuration
        wdog_en <= 1'b0;
        wr(TIMER_CFG_OFS, 32'h0);
        b = n_resets;
        repeat (3 * WC) @(posedge clk);
        `CHK("disabled_resets", b, n_resets)
        tally_and_finish();
    end
endmodule
